// File: rtl/dcr_channel.sv
// DMA channel: registers, block transfer engine, AXI4-Lite slave, interrupt
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`default_nettype none
// How it works
// - Interrupt request raised when a status bit and its mask bit are both set; done status needs interrupt enable.
// - NMI during a running transfer ends it and sets the abort status bit.
// - Writing one to the start bit begins a transfer; hardware clears the bit.
// - Source register gives first read location of a block.
// - Programmed source address is never changed by hardware; a working copy steps.
// - Destination register gives first written location of a block.
// - Programmed destination address is never changed by hardware.
// - Address registers hold 20 bits; bits 31 to 20 read zero.
// - Low-half-only write to source loads bits 15 to 0, clears 19 to 16.
// - Low-half-only write to destination loads bits 15 to 0, clears 19 to 16.
// - Size register holds item count of one block.
// - Size count drops by one after every item moved except the last.
// - On the last item, instead of reaching zero, the count reloads the last programmed size at once.
// - Programmed size zero disables transfers entirely.
// - Nonzero size N moves exactly N items.
module dcr_channel (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [dcr_pkg::AXI_AW-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [dcr_pkg::AXI_AW-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic trigger_in, // Transfer trigger pin
	input wire logic nmi_in, // Non-maskable interrupt pin
	output dcr_pkg::dcr_mem_s mem_o, // Memory request
	input wire logic mem_ack, // Memory request accepted
	input wire logic [dcr_pkg::DATA_W-1:0] mem_rdata, // Read data, valid with ack
	output logic irq // Interrupt, level
);
	dcr_pkg::dcr_state_s s_ff;
	dcr_pkg::dcr_state_s nxt_s;
	logic trig_s;
	logic trig_d;
	logic nmi_s;
	logic wr_fire;
	logic ctl_wr;
	logic sa_wr;
	logic da_wr;
	logic sz_wr;
	logic trig_hit;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	assign trig_s = s_ff.trig_p[1];
	assign trig_d = s_ff.trig_p[2];
	assign nmi_s = s_ff.nmi_p[1];
	assign wr_fire = s_ff.aw_got && s_ff.w_got && !s_ff.bvalid;
	assign ctl_wr = wr_fire && s_ff.awaddr == dcr_pkg::OFS_CTL;
	assign sa_wr = wr_fire && s_ff.awaddr == dcr_pkg::OFS_SA;
	assign da_wr = wr_fire && s_ff.awaddr == dcr_pkg::OFS_DA;
	assign sz_wr = wr_fire && s_ff.awaddr == dcr_pkg::OFS_SZ;
	// Level mode starts on high; edge mode needs a fresh rising edge
	assign trig_hit = s_ff.lvl ? trig_s : (trig_s && !trig_d);

	always_comb begin
		logic [31:0] m;
		logic [dcr_pkg::ADDR_W-1:0] src_n;
		m = 32'h0000_0000;
		src_n = s_ff.src_w + dcr_pkg::ADDR_STEP;
		nxt_s = s_ff;
		// Pin synchronisers, first stage read only by the second
		nxt_s.trig_p = {s_ff.trig_p[1:0], trigger_in};
		nxt_s.nmi_p = {s_ff.nmi_p[0], nmi_in};

		// Write channel: address and data taken in either order
		if (s_ff.awready && s_axi_awvalid) begin
			nxt_s.aw_got = 1'b1;
			nxt_s.awaddr = s_axi_awaddr;
		end
		if (s_ff.wready && s_axi_wvalid) begin
			nxt_s.w_got = 1'b1;
			nxt_s.wdata = s_axi_wdata;
			nxt_s.wstrb = s_axi_wstrb;
		end
		if (s_ff.bvalid && s_axi_bready) begin
			nxt_s.bvalid = 1'b0;
		end
		if (wr_fire) begin
			nxt_s.aw_got = 1'b0;
			nxt_s.w_got = 1'b0;
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp = dcr_pkg::RESP_OKAY;
			if (ctl_wr) begin
				if (s_ff.wstrb[0]) begin
					nxt_s.lvl = s_ff.wdata[dcr_pkg::CTL_LVL];
					nxt_s.en = s_ff.wdata[dcr_pkg::CTL_EN];
					nxt_s.pend = s_ff.wdata[dcr_pkg::CTL_PEND];
					nxt_s.ie = s_ff.wdata[dcr_pkg::CTL_IE];
					nxt_s.abort = s_ff.wdata[dcr_pkg::CTL_ABORT];
					nxt_s.start = s_ff.wdata[dcr_pkg::CTL_START];
				end
			end else if (sa_wr) begin
				m = merge_bytes({12'h000, s_ff.sa}, s_ff.wdata, s_ff.wstrb);
				// Half-word write leaves the upper nibble cleared
				nxt_s.sa = s_ff.wstrb[2] ? m[19:0] : {4'h0, m[15:0]};
			end else if (da_wr) begin
				m = merge_bytes({12'h000, s_ff.da}, s_ff.wdata, s_ff.wstrb);
				nxt_s.da = s_ff.wstrb[2] ? m[19:0] : {4'h0, m[15:0]};
			end else if (sz_wr) begin
				m = merge_bytes({16'h0000, s_ff.prog}, s_ff.wdata, s_ff.wstrb);
				nxt_s.prog = m[15:0];
				nxt_s.cnt = m[15:0];
			end else if (s_ff.awaddr == dcr_pkg::OFS_IST) begin
				nxt_s.ist = s_ff.ist & ~s_ff.wdata[dcr_pkg::IST_W-1:0];
			end else if (s_ff.awaddr == dcr_pkg::OFS_IMASK) begin
				nxt_s.imask = s_ff.wdata[dcr_pkg::IST_W-1:0];
			end else begin
				nxt_s.bresp = dcr_pkg::RESP_SLVERR;
			end
		end

		// Read channel
		if (s_ff.rvalid && s_axi_rready) begin
			nxt_s.rvalid = 1'b0;
		end
		if (s_ff.arready && s_axi_arvalid) begin
			nxt_s.rvalid = 1'b1;
			nxt_s.rresp = dcr_pkg::RESP_OKAY;
			nxt_s.rdata = 32'h0000_0000;
			if (s_axi_araddr == dcr_pkg::OFS_CTL) begin
				nxt_s.rdata[dcr_pkg::CTL_LVL] = s_ff.lvl;
				nxt_s.rdata[dcr_pkg::CTL_EN] = s_ff.en;
				nxt_s.rdata[dcr_pkg::CTL_PEND] = s_ff.pend;
				nxt_s.rdata[dcr_pkg::CTL_IE] = s_ff.ie;
				nxt_s.rdata[dcr_pkg::CTL_ABORT] = s_ff.abort;
				nxt_s.rdata[dcr_pkg::CTL_START] = s_ff.start;
			end else if (s_axi_araddr == dcr_pkg::OFS_SA) begin
				nxt_s.rdata = {12'h000, s_ff.sa};
			end else if (s_axi_araddr == dcr_pkg::OFS_DA) begin
				nxt_s.rdata = {12'h000, s_ff.da};
			end else if (s_axi_araddr == dcr_pkg::OFS_SZ) begin
				nxt_s.rdata = {16'h0000, s_ff.cnt};
			end else if (s_axi_araddr == dcr_pkg::OFS_IST) begin
				nxt_s.rdata = {30'h0000_0000, s_ff.ist};
			end else if (s_axi_araddr == dcr_pkg::OFS_IMASK) begin
				nxt_s.rdata = {30'h0000_0000, s_ff.imask};
			end else begin
				nxt_s.rresp = dcr_pkg::RESP_SLVERR;
			end
		end

		// Transfer engine; its flag sets come after software writes so they win
		case (s_ff.st)
			dcr_pkg::ST_IDLE: begin
				if (s_ff.en && s_ff.prog != dcr_pkg::SIZE_ZERO && !nmi_s
						&& (s_ff.start || trig_hit)) begin
					// A fresh start written this cycle survives the clear
					if (!(ctl_wr && s_ff.wstrb[0] && s_ff.wdata[dcr_pkg::CTL_START])) begin
						nxt_s.start = 1'b0;
					end
					nxt_s.st = dcr_pkg::ST_RD;
					nxt_s.src_w = s_ff.sa;
					nxt_s.dst_w = s_ff.da;
					nxt_s.cnt = s_ff.prog;
					nxt_s.mem.req = 1'b1;
					nxt_s.mem.we = 1'b0;
					nxt_s.mem.addr = s_ff.sa;
				end
			end
			dcr_pkg::ST_RD: begin
				if (mem_ack) begin
					nxt_s.st = dcr_pkg::ST_WR;
					nxt_s.mem.we = 1'b1;
					nxt_s.mem.addr = s_ff.dst_w;
					nxt_s.mem.wdata = mem_rdata;
				end
			end
			dcr_pkg::ST_WR: begin
				if (mem_ack) begin
					nxt_s.src_w = src_n;
					nxt_s.dst_w = s_ff.dst_w + dcr_pkg::ADDR_STEP;
					if (s_ff.cnt == dcr_pkg::SIZE_ONE) begin
						// Last of N items: reload and flag
						nxt_s.cnt = s_ff.prog;
						nxt_s.st = dcr_pkg::ST_IDLE;
						nxt_s.mem.req = 1'b0;
						nxt_s.mem.we = 1'b0;
						nxt_s.pend = 1'b1;
						if (s_ff.ie) begin
							nxt_s.ist[dcr_pkg::IST_DONE] = 1'b1;
						end
					end else begin
						nxt_s.cnt = s_ff.cnt - dcr_pkg::SIZE_ONE;
						nxt_s.st = dcr_pkg::ST_RD;
						nxt_s.mem.we = 1'b0;
						nxt_s.mem.addr = src_n;
					end
				end
			end
			default: begin
				nxt_s.st = dcr_pkg::ST_IDLE;
			end
		endcase
		// Abort drops the request mid-handshake; memory must tolerate it
		if (s_ff.st != dcr_pkg::ST_IDLE && (nmi_s || !s_ff.en)) begin
			nxt_s.st = dcr_pkg::ST_IDLE;
			nxt_s.mem.req = 1'b0;
			nxt_s.mem.we = 1'b0;
			nxt_s.cnt = s_ff.prog;
			if (nmi_s) begin
				nxt_s.abort = 1'b1;
				nxt_s.ist[dcr_pkg::IST_ABORT] = 1'b1;
			end
		end

		nxt_s.awready = !nxt_s.aw_got && !nxt_s.bvalid;
		nxt_s.wready = !nxt_s.w_got && !nxt_s.bvalid;
		nxt_s.arready = !nxt_s.rvalid;
		nxt_s.irq = |(nxt_s.ist & nxt_s.imask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign s_axi_awready = s_ff.awready;
	assign s_axi_wready = s_ff.wready;
	assign s_axi_bvalid = s_ff.bvalid;
	assign s_axi_bresp = s_ff.bresp;
	assign s_axi_arready = s_ff.arready;
	assign s_axi_rvalid = s_ff.rvalid;
	assign s_axi_rresp = s_ff.rresp;
	assign s_axi_rdata = s_ff.rdata;
	assign mem_o = s_ff.mem;
	assign irq = s_ff.irq;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_edge_only: assert property (
		s_ff.st == dcr_pkg::ST_IDLE && !s_ff.lvl && !s_ff.start && !(trig_s && !trig_d)
		|=> s_ff.st == dcr_pkg::ST_IDLE)
		else $error("edge mode started without a rising edge");
	chk_level_start: assert property (
		s_ff.st == dcr_pkg::ST_IDLE && s_ff.lvl && trig_s && s_ff.en && !nmi_s
		&& s_ff.prog != dcr_pkg::SIZE_ZERO |=> s_ff.st == dcr_pkg::ST_RD)
		else $error("level trigger did not start transfer");
	chk_idle_off: assert property (
		!s_ff.en |=> s_ff.st == dcr_pkg::ST_IDLE)
		else $error("transfer while channel disabled");
	chk_irq_cause: assert property (
		$rose(s_ff.pend) && $past(s_ff.st) == dcr_pkg::ST_WR && !$past(ctl_wr)
		&& $past(s_ff.ie)
		|-> s_ff.ist[dcr_pkg::IST_DONE])
		else $error("done without interrupt status");
	chk_nmi_abort: assert property (
		nmi_s && s_ff.st != dcr_pkg::ST_IDLE
		|=> s_ff.abort && s_ff.st == dcr_pkg::ST_IDLE && !s_ff.mem.req)
		else $error("nmi did not abort transfer");
	chk_start_clear: assert property (
		s_ff.st == dcr_pkg::ST_IDLE && s_ff.start && s_ff.en && !nmi_s && !ctl_wr
		&& s_ff.prog != dcr_pkg::SIZE_ZERO |=> !s_ff.start ##0 s_ff.mem.req)
		else $error("start bit not cleared on start");
	chk_src_hold: assert property (
		s_ff.st != dcr_pkg::ST_IDLE && !sa_wr |=> $stable(s_ff.sa))
		else $error("source register changed by hardware");
	chk_dst_hold: assert property (
		s_ff.st != dcr_pkg::ST_IDLE && !da_wr |=> $stable(s_ff.da))
		else $error("destination register changed by hardware");
	chk_rd_upper: assert property (
		s_ff.rvalid |-> s_ff.rdata[31:20] == 12'h000)
		else $error("reserved read bits not zero");
	chk_half_write: assert property (
		sa_wr && !s_ff.wstrb[2] && !s_ff.wstrb[3] |=> s_ff.sa[19:16] == 4'h0)
		else $error("half write kept upper source bits");
	chk_count_down: assert property (
		s_ff.st == dcr_pkg::ST_WR && mem_ack && s_ff.en && !nmi_s && !sz_wr
		&& s_ff.cnt != dcr_pkg::SIZE_ONE |=> s_ff.cnt == $past(s_ff.cnt) - dcr_pkg::SIZE_ONE)
		else $error("count did not step down");
	chk_reload: assert property (
		s_ff.st == dcr_pkg::ST_WR && mem_ack && s_ff.en && !nmi_s && !sz_wr
		&& s_ff.cnt == dcr_pkg::SIZE_ONE
		|=> s_ff.cnt == $past(s_ff.prog) && s_ff.pend && s_ff.st == dcr_pkg::ST_IDLE)
		else $error("count not reloaded at end of block");
	chk_zero_size: assert property (
		s_ff.prog == dcr_pkg::SIZE_ZERO && s_ff.st == dcr_pkg::ST_IDLE
		|=> s_ff.st == dcr_pkg::ST_IDLE)
		else $error("transfer with zero size");
	chk_edge_start: assert property (
		s_ff.st == dcr_pkg::ST_IDLE && !s_ff.lvl && trig_s && !trig_d && s_ff.en && !nmi_s
		&& s_ff.prog != dcr_pkg::SIZE_ZERO |=> s_ff.st == dcr_pkg::ST_RD)
		else $error("rising trigger edge did not start transfer");
	chk_start_kept: assert property (
		s_ff.start && !s_ff.en && !ctl_wr
		|=> s_ff.start)
		else $error("disabled channel consumed a start");
	chk_done_gated: assert property (
		!s_ff.ie && !s_ff.ist[dcr_pkg::IST_DONE]
		|=> !s_ff.ist[dcr_pkg::IST_DONE])
		else $error("done status set with interrupt disabled");
	chk_done_sticky: assert property (
		s_ff.ist[dcr_pkg::IST_DONE] && !(wr_fire && s_ff.awaddr == dcr_pkg::OFS_IST)
		|=> s_ff.ist[dcr_pkg::IST_DONE])
		else $error("done status lost without a clear");
	chk_pend_done: assert property (
		s_ff.st == dcr_pkg::ST_WR && mem_ack && s_ff.cnt == dcr_pkg::SIZE_ONE
		|=> s_ff.pend)
		else $error("pending flag not set at end of block");
	chk_abort_cause: assert property (
		!s_ff.abort && !nmi_s && !ctl_wr
		|=> !s_ff.abort)
		else $error("abort status set without nmi");
	chk_nmi_hold: assert property (
		nmi_s && s_ff.st == dcr_pkg::ST_IDLE
		|=> s_ff.st == dcr_pkg::ST_IDLE)
		else $error("transfer started during nmi");
	chk_first_read: assert property (
		$rose(s_ff.mem.req)
		|-> !s_ff.mem.we && s_ff.mem.addr == $past(s_ff.sa))
		else $error("first read not at source address");
	chk_src_step: assert property (
		s_ff.st == dcr_pkg::ST_WR && mem_ack && s_ff.en && !nmi_s
		&& s_ff.cnt != dcr_pkg::SIZE_ONE
		|=> s_ff.mem.addr == $past(s_ff.src_w) + dcr_pkg::ADDR_STEP)
		else $error("working source address did not step");
	chk_first_write: assert property (
		$rose(s_ff.mem.req)
		|-> s_ff.dst_w == $past(s_ff.da))
		else $error("working destination not at programmed address");
	chk_write_item: assert property (
		s_ff.st == dcr_pkg::ST_RD && mem_ack && s_ff.en && !nmi_s
		|=> s_ff.mem.we && s_ff.mem.wdata == $past(mem_rdata) && s_ff.mem.addr == s_ff.dst_w)
		else $error("write phase lost item or address");
	chk_dst_half: assert property (
		da_wr && !s_ff.wstrb[2]
		|=> s_ff.da[19:16] == 4'h0)
		else $error("half write kept upper destination bits");
	chk_size_load: assert property (
		sz_wr && s_ff.wstrb[1:0] == 2'h3
		|=> s_ff.prog == $past(s_ff.wdata[15:0]))
		else $error("size register not loaded");
	chk_count_still: assert property (
		s_ff.st != dcr_pkg::ST_IDLE && !(s_ff.st == dcr_pkg::ST_WR && mem_ack) && !sz_wr
		&& s_ff.en && !nmi_s |=> $stable(s_ff.cnt))
		else $error("count moved without an item");
	chk_zero_quiet: assert property (
		s_ff.prog == dcr_pkg::SIZE_ZERO && s_ff.st == dcr_pkg::ST_IDLE
		|=> !s_ff.mem.req)
		else $error("memory request with zero size");
	chk_block_end: assert property (
		s_ff.st == dcr_pkg::ST_WR && mem_ack && s_ff.cnt == dcr_pkg::SIZE_ONE
		|=> !s_ff.mem.req && s_ff.st == dcr_pkg::ST_IDLE)
		else $error("transfer ran past the block size");
endmodule
`default_nettype wire

// File: rtl/dcr_pkg.sv
// Shared constants, states and carriers of the DMA channel register block
`default_nettype none
package dcr_pkg;
	localparam int AXI_AW = 8;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int SIZE_W = 16;
	// Register byte addresses
	localparam logic [AXI_AW-1:0] OFS_CTL = 8'h00;
	localparam logic [AXI_AW-1:0] OFS_SA = 8'h04;
	localparam logic [AXI_AW-1:0] OFS_DA = 8'h08;
	localparam logic [AXI_AW-1:0] OFS_SZ = 8'h0C;
	localparam logic [AXI_AW-1:0] OFS_IST = 8'h10;
	localparam logic [AXI_AW-1:0] OFS_IMASK = 8'h14;
	// Control register bit positions
	localparam int CTL_START = 0;
	localparam int CTL_ABORT = 1;
	localparam int CTL_IE = 2;
	localparam int CTL_PEND = 3;
	localparam int CTL_EN = 4;
	localparam int CTL_LVL = 5;
	// Interrupt status bit positions
	localparam int IST_DONE = 0;
	localparam int IST_ABORT = 1;
	localparam int IST_W = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 20'h00002;
	localparam logic [SIZE_W-1:0] SIZE_ONE = 16'h0001;
	localparam logic [SIZE_W-1:0] SIZE_ZERO = 16'h0000;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RD,
		ST_WR
	} dcr_state_e;

	typedef struct packed {
		logic req;
		logic we;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} dcr_mem_s;

	typedef struct packed {
		dcr_state_e st;
		logic aw_got;
		logic w_got;
		logic [AXI_AW-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic lvl;
		logic en;
		logic pend;
		logic ie;
		logic abort;
		logic start;
		logic [ADDR_W-1:0] sa;
		logic [ADDR_W-1:0] da;
		logic [ADDR_W-1:0] src_w;
		logic [ADDR_W-1:0] dst_w;
		logic [SIZE_W-1:0] cnt;
		logic [SIZE_W-1:0] prog;
		logic [IST_W-1:0] ist;
		logic [IST_W-1:0] imask;
		logic irq;
		logic [2:0] trig_p;
		logic [1:0] nmi_p;
		dcr_mem_s mem;
	} dcr_state_s;
endpackage
`default_nettype wire

// File: tb/dcr_mem_model.sv
// Memory partner that answers the channel's item requests
`default_nettype none
module dcr_mem_model (
	input wire logic aclk, // System clock
	input wire dcr_pkg::dcr_mem_s mem_i, // Request from channel
	output logic mem_ack, // Request taken
	output logic [dcr_pkg::DATA_W-1:0] mem_rdata // Read data, valid with ack
);
	timeunit 1ns;
	timeprecision 1ps;
	integer seed = 32'h94e2582b;
	int wait_n = 0;
	initial begin
		mem_ack = 1'b0;
		mem_rdata = 16'h0000;
	end
	// Random 0..3 cycle stall; stale data flips so it never looks valid
	always @(posedge aclk) begin
		if (mem_ack || !mem_i.req) begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			wait_n <= $unsigned($random(seed)) % 4;
		end else if (wait_n == 0) begin
			mem_ack <= 1'b1;
			mem_rdata <= mem_i.addr[15:0] ^ 16'h5A3C;
		end else begin
			wait_n <= wait_n - 1;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule
`default_nettype wire

// File: tb/dcr_channel_tb.sv
// Self-checking bench of the DMA channel register block
`default_nettype none
module dcr_channel_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, trig, nmi;
	logic awready, wready, bvalid, arready, rvalid, mem_ack, irq;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [15:0] mem_rdata;
	logic [19:0] rd_a;
	dcr_pkg::dcr_mem_s mem_o;
	integer seed = 32'h94e2582b;
	int n_mismatch = 0, cmp_count = 0, idx = 0, cur_sa, cur_da, cur_sz;
	dcr_channel DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .trigger_in(trig), .nmi_in(nmi), .mem_o(mem_o),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .irq(irq));
	dcr_mem_model mem (.aclk(aclk), .mem_i(mem_o), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("Compares %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Each channel released on its own handshake edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
			input logic [1:0] er);
		int t;
		t = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			t++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!(bvalid === 1'b1) && t < 200);
		bready <= 1'b0;
		chk({31'h0, bvalid}, 32'h1);
		chk({30'h0, bresp}, {30'h0, er});
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		int t;
		t = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			t++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!(rvalid === 1'b1) && t < 200);
		d = rdata;
		chk({31'h0, rvalid}, 32'h1);
		rready <= 1'b0;
		chk({30'h0, rresp}, {30'h0, er});
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		rd(a, d, er);
		chk(d, e);
	endtask
	task automatic setup(input int sz);
		cur_sa = $unsigned($random(seed)) & 32'hFFFF0;
		cur_da = $unsigned($random(seed)) & 32'hFFFF0;
		cur_sz = sz;
		idx = 0;
		wr(dcr_pkg::OFS_SA, cur_sa, 4'hF, dcr_pkg::RESP_OKAY);
		wr(dcr_pkg::OFS_DA, cur_da, 4'hF, dcr_pkg::RESP_OKAY);
		wr(dcr_pkg::OFS_SZ, sz, 4'hF, dcr_pkg::RESP_OKAY);
	endtask
	task automatic wait_items(input int n);
		int t;
		t = 0;
		while (idx < n && t < 3000) begin
			@(posedge aclk);
			t++;
		end
		if (idx < n) begin
			n_mismatch++;
			$display("mismatch at %0t: item wait timed out", $time);
		end
		repeat (6) @(posedge aclk);
	endtask
	// Reference for every item moved: read SA+2i, write DA+2i with read data
	always @(posedge aclk) begin
		if (aresetn && mem_o.req && mem_ack) begin
			if (!mem_o.we) begin
				chk({12'h000, mem_o.addr}, cur_sa + 2 * (idx % cur_sz));
				rd_a = mem_o.addr;
			end else begin
				chk({12'h000, mem_o.addr}, cur_da + 2 * (idx % cur_sz));
				chk({16'h0000, mem_o.wdata}, {16'h0000, rd_a[15:0] ^ 16'h5A3C});
				idx++;
			end
		end
	end
	initial begin
		#400000;
		n_mismatch++;
		give_verdict();
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, trig, nmi} = 8'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h00000000;
		wstrb = 4'h0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rdc(dcr_pkg::OFS_CTL, 32'h0, dcr_pkg::RESP_OKAY);
		rdc(dcr_pkg::OFS_SZ, 32'h0, dcr_pkg::RESP_OKAY);
		rdc(8'h18, 32'h0, dcr_pkg::RESP_SLVERR);
		wr(8'h18, 32'hFFFFFFFF, 4'hF, dcr_pkg::RESP_SLVERR);
		for (int i = 0; i < 2; i++) begin
			v = $random(seed);
			wr(i ? dcr_pkg::OFS_DA : dcr_pkg::OFS_SA, v, 4'hF, dcr_pkg::RESP_OKAY);
			rdc(i ? dcr_pkg::OFS_DA : dcr_pkg::OFS_SA, v & 32'hFFFFF, dcr_pkg::RESP_OKAY);
			wr(i ? dcr_pkg::OFS_DA : dcr_pkg::OFS_SA, v, 4'h3, dcr_pkg::RESP_OKAY);
			rdc(i ? dcr_pkg::OFS_DA : dcr_pkg::OFS_SA, v & 32'hFFFF, dcr_pkg::RESP_OKAY);
		end
		setup(3);
		wr(dcr_pkg::OFS_IMASK, 32'h1, 4'hF, dcr_pkg::RESP_OKAY);
		wr(dcr_pkg::OFS_CTL, 32'h15, 4'hF, dcr_pkg::RESP_OKAY);
		wait_items(3);
		chk(idx, 3);
		rdc(dcr_pkg::OFS_CTL, 32'h1C, dcr_pkg::RESP_OKAY);
		rdc(dcr_pkg::OFS_SA, cur_sa, dcr_pkg::RESP_OKAY);
		rdc(dcr_pkg::OFS_DA, cur_da, dcr_pkg::RESP_OKAY);
		rdc(dcr_pkg::OFS_SZ, 3, dcr_pkg::RESP_OKAY);
		chk({31'h0, irq}, 1);
		wr(dcr_pkg::OFS_IST, 32'h1, 4'hF, dcr_pkg::RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 0);
		setup(0);
		wr(dcr_pkg::OFS_CTL, 32'h11, 4'hF, dcr_pkg::RESP_OKAY);
		repeat (30) @(posedge aclk);
		chk(idx, 0);
		// Start stays pending at size zero; drop it before a new size is loaded
		wr(dcr_pkg::OFS_CTL, 32'h0, 4'hF, dcr_pkg::RESP_OKAY);
		setup(2);
		wr(dcr_pkg::OFS_CTL, 32'h01, 4'hF, dcr_pkg::RESP_OKAY);
		trig <= 1'b1;
		repeat (30) @(posedge aclk);
		chk(idx, 0);
		trig <= 1'b0;
		wr(dcr_pkg::OFS_CTL, 32'h10, 4'hF, dcr_pkg::RESP_OKAY);
		trig <= 1'b1;
		wait_items(2);
		repeat (40) @(posedge aclk);
		chk(idx, 2);
		trig <= 1'b0;
		wr(dcr_pkg::OFS_CTL, 32'h30, 4'hF, dcr_pkg::RESP_OKAY);
		trig <= 1'b1;
		wait_items(6);
		trig <= 1'b0;
		wait_items(idx + 2 - idx % 2);
		chk({31'h0, idx >= 6 && idx % 2 == 0}, 1);
		chk({31'h0, irq}, 0);
		setup(8);
		wr(dcr_pkg::OFS_IMASK, 32'h0, 4'hF, dcr_pkg::RESP_OKAY);
		wr(dcr_pkg::OFS_CTL, 32'h11, 4'hF, dcr_pkg::RESP_OKAY);
		wait_items(1);
		nmi <= 1'b1;
		repeat (10) @(posedge aclk);
		nmi <= 1'b0;
		rd(dcr_pkg::OFS_CTL, v, dcr_pkg::RESP_OKAY);
		chk(v & 32'h2, 32'h2);
		chk({31'h0, idx < 8}, 1);
		chk({31'h0, irq}, 0);
		wr(dcr_pkg::OFS_IMASK, 32'h2, 4'hF, dcr_pkg::RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 1);
		wr(dcr_pkg::OFS_IST, 32'h3, 4'hF, dcr_pkg::RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 0);
		give_verdict();
	end
endmodule
`default_nettype wire
